// ---- design/cpu_status_flag_logic.sv ----
// Status word, arithmetic modes and request-bit visibility of the core
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module cpu_status_flag_logic
    import cpu_flag_pkg::*;
(
    input  wire logic              clk,        // Core clock
    input  wire logic              arst_n,     // Async reset, low
    input  wire logic              psel,       // APB select
    input  wire logic              penable,    // APB access phase
    input  wire logic              pwrite,     // APB write
    input  wire logic [APB_AW-1:0] paddr,      // APB byte address
    input  wire logic [APB_DW-1:0] pwdata,     // APB write data
    input  wire logic [3:0]        pstrb,      // APB byte strobes
    output logic      [APB_DW-1:0] prdata,     // APB read data
    output logic                   pready,     // APB ready
    output logic                   pslverr,    // APB error
    input  wire logic [DATA_W-1:0] irq_set,    // Peripheral requests
    output logic [DATA_W-1:0]      processor_status_word, // Flags
    output logic                   branch_taken,          // Test outcome
    output logic                   instr_done             // Exec pulse
);

    // ==================
    // Architectural state
    logic [DATA_W-1:0] acc_q,     acc_d;      // Accumulator
    logic [DATA_W-1:0] xmem_q,    xmem_d;     // Byte addressed by X
    logic [DATA_W-1:0] opnd_q,    opnd_d;     // Memory operand
    logic [DATA_W-1:0] yreg_q,    yreg_d;     // Y register
    logic [DATA_W-1:0] psw_q,     psw_d;      // Status word
    logic [DATA_W-1:0] req_q,     req_d;      // Request bits
    logic [DATA_W-1:0] vis_q,     vis_d;      // Request bits as tested
    logic [INSTR_OP_W-1:0]  op_q, op_d;       // Last opcode
    logic [INSTR_BIT_W-1:0] bsel_q, bsel_d;   // Last tested bit
    logic              taken_q,   taken_d;    // Last branch outcome
    logic              done_q,    done_d;     // Execution pulse

    // ==================
    // Bus decode
    logic              access;                // Access phase
    logic              wr_lo;                 // Write to low byte
    logic              mapped;                // Address decodes
    logic [DATA_W-1:0] rd_byte;               // Selected read value
    logic [DATA_W-1:0] wbyte;                 // Written byte
    logic              exec;                  // Instruction issued
    opcode_t           new_op;                // Issued opcode
    logic [INSTR_BIT_W-1:0] new_bit;          // Issued bit index
    logic              t_mode;                // Index memory mode
    logic [DATA_W-1:0] instr_view;            // Instruction readback

    alu_if alu ();                            // Arithmetic bundle

    // ==================
    // Arithmetic units
    bcd_addsub u_addsub (
        .alu (alu.addsub)
    );

    mul_div_unit u_muldiv (
        .alu (alu.muldiv)
    );

    // ==================
    // APB handshake: zero wait states
    assign pready  = 1'b1;
    assign access  = psel & penable;
    assign wbyte   = pwdata[DATA_W-1:0];
    assign wr_lo   = access & pwrite & pstrb[0];
    assign pslverr = access & ~mapped;

    // Instruction fields from the written byte
    assign new_op  = opcode_t'(wbyte[INSTR_OP_LSB +: INSTR_OP_W]);
    assign new_bit = wbyte[INSTR_BIT_LSB +: INSTR_BIT_W];
    assign exec    = wr_lo & (paddr == ADDR_INSTR);
    assign t_mode  = psw_q[PSW_T];

    // Readback of the last instruction with its outcome
    always_comb begin
        instr_view = {DATA_W{1'b0}};
        instr_view[INSTR_OP_LSB +: INSTR_OP_W]   = op_q;
        instr_view[INSTR_BIT_LSB +: INSTR_BIT_W] = bsel_q;
        instr_view[INSTR_TAKEN]                  = taken_q;
    end

    // ==================
    // Read decode; unmapped reads return zero
    always_comb begin
        mapped  = 1'b1;
        rd_byte = {DATA_W{1'b0}};
        case (paddr)
            ADDR_ACC:     rd_byte = acc_q;        // Accumulator
            ADDR_XMEM:    rd_byte = xmem_q;       // Byte at X
            ADDR_OPND:    rd_byte = opnd_q;       // Operand
            ADDR_PSW:     rd_byte = psw_q;        // Flags
            ADDR_INSTR:   rd_byte = instr_view;   // Last instruction
            ADDR_YREG:    rd_byte = yreg_q;       // Y register
            ADDR_IRQ_REQ: rd_byte = req_q;        // Live requests
            ADDR_IRQ_VIS: rd_byte = vis_q;        // Tested copy
            default:      mapped  = 1'b0;         // Not a register
        endcase
    end

    assign prdata = (access & ~pwrite & mapped)
                    ? {{(APB_DW-DATA_W){1'b0}}, rd_byte}
                    : {APB_DW{1'b0}};

    // ==================
    // Operand steering into the arithmetic units
    always_comb begin
        // Multiply/divide always take accumulator, index mode ignored
        if (new_op == OP_MUL || new_op == OP_DIV) begin
            alu.a = acc_q;
        end else begin
            alu.a = t_mode ? xmem_q : acc_q;
        end
        alu.b        = opnd_q;
        alu.hi       = yreg_q;
        alu.carry_in = psw_q[PSW_C];
        alu.subtract = (new_op == OP_SBC);
        alu.decimal  = psw_q[PSW_D];
        alu.is_div   = (new_op == OP_DIV);
    end

    // ==================
    // Next state of registers and flags
    always_comb begin
        acc_d   = acc_q;
        xmem_d  = xmem_q;
        opnd_d  = opnd_q;
        yreg_d  = yreg_q;
        psw_d   = psw_q;
        vis_d   = vis_q;
        op_d    = op_q;
        bsel_d  = bsel_q;
        taken_d = taken_q;
        done_d  = exec;
        req_d   = req_q;

        // Software register writes
        if (wr_lo) begin
            case (paddr)
                ADDR_ACC:     acc_d  = wbyte;     // Load accumulator
                ADDR_XMEM:    xmem_d = wbyte;     // Load byte at X
                ADDR_OPND:    opnd_d = wbyte;     // Load operand
                ADDR_PSW:     psw_d  = wbyte;     // Load flags
                ADDR_YREG:    yreg_d = wbyte;     // Load Y
                ADDR_IRQ_REQ: req_d  = wbyte;     // Write requests
                default:      ;                   // Others read-only
            endcase
        end
        // Peripheral events win over a clearing write
        req_d = req_d | irq_set;

        // Instruction execution
        if (exec) begin
            op_d   = new_op;
            bsel_d = new_bit;
            // The next instruction's test sees request state as of this issue
            vis_d  = req_q;
            case (new_op)
                OP_ADC, OP_SBC: begin
                    // Index mode sends the result to the byte at X
                    if (t_mode) begin
                        xmem_d = alu.sum;
                    end else begin
                        acc_d = alu.sum;
                    end
                    psw_d[PSW_C] = alu.carry_out;
                    // Only meaningful in binary mode
                    psw_d[PSW_V] = alu.ovf;
                    psw_d[PSW_N] = alu.sum[DATA_W-1];
                    psw_d[PSW_Z] = (alu.sum == {DATA_W{1'b0}});
                end
                OP_SEC: psw_d[PSW_C] = 1'b1;      // Set carry
                OP_CLC: psw_d[PSW_C] = 1'b0;      // Clear carry
                OP_SED: psw_d[PSW_D] = 1'b1;      // Enter decimal
                OP_CLD: psw_d[PSW_D] = 1'b0;      // Leave decimal
                OP_SEI: psw_d[PSW_I] = 1'b1;      // Mask interrupts
                OP_CLI: psw_d[PSW_I] = 1'b0;      // Unmask interrupts
                OP_SET: psw_d[PSW_T] = 1'b1;      // Index memory mode
                OP_CLT: psw_d[PSW_T] = 1'b0;      // Accumulator mode
                OP_MUL, OP_DIV: begin
                    // Results only; flags stay as they were
                    acc_d  = alu.md_lo;
                    yreg_d = alu.md_hi;
                    psw_d  = psw_q;
                end
                OP_BBS: begin
                    // Delayed copy, so a fresh write is not yet seen
                    taken_d = vis_q[new_bit];
                end
                OP_BBC: begin
                    taken_d = ~vis_q[new_bit];
                end
                default: ;                        // No operation
            endcase
        end
    end

    // ==================
    // State registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_q   <= {DATA_W{1'b0}};
            xmem_q  <= {DATA_W{1'b0}};
            opnd_q  <= {DATA_W{1'b0}};
            yreg_q  <= {DATA_W{1'b0}};
            psw_q   <= PSW_RESET;
            req_q   <= {DATA_W{1'b0}};
            vis_q   <= {DATA_W{1'b0}};
            op_q    <= OP_NOP;
            bsel_q  <= {INSTR_BIT_W{1'b0}};
            taken_q <= 1'b0;
            done_q  <= 1'b0;
        end else begin
            acc_q   <= acc_d;
            xmem_q  <= xmem_d;
            opnd_q  <= opnd_d;
            yreg_q  <= yreg_d;
            psw_q   <= psw_d;
            req_q   <= req_d;
            vis_q   <= vis_d;
            op_q    <= op_d;
            bsel_q  <= bsel_d;
            taken_q <= taken_d;
            done_q  <= done_d;
        end
    end

    // ==================
    // Outputs straight from flops
    assign processor_status_word = psw_q;
    assign branch_taken          = taken_q;
    assign instr_done            = done_q;

endmodule : cpu_status_flag_logic
`default_nettype wire

// ---- design/cpu_flag_pkg.sv ----
// Constants, field layout and opcodes shared by the status-flag core
package cpu_flag_pkg;

    // ==================
    // Data and bus widths
    localparam int unsigned DATA_W = 8;        // Core data width
    localparam int unsigned APB_AW = 8;        // APB address width
    localparam int unsigned APB_DW = 32;       // APB data width

    // ==================
    // Register byte addresses
    localparam logic [APB_AW-1:0] ADDR_ACC     = 8'h00; // Accumulator
    localparam logic [APB_AW-1:0] ADDR_XMEM    = 8'h04; // Byte at X
    localparam logic [APB_AW-1:0] ADDR_OPND    = 8'h08; // Memory operand
    localparam logic [APB_AW-1:0] ADDR_PSW     = 8'h0c; // Status word
    localparam logic [APB_AW-1:0] ADDR_INSTR   = 8'h10; // Instruction
    localparam logic [APB_AW-1:0] ADDR_YREG    = 8'h14; // Y register
    localparam logic [APB_AW-1:0] ADDR_IRQ_REQ = 8'h18; // Request bits
    localparam logic [APB_AW-1:0] ADDR_IRQ_VIS = 8'h1c; // Seen by tests

    // ==================
    // Status word bit positions
    localparam int unsigned PSW_C = 0;         // Carry
    localparam int unsigned PSW_Z = 1;         // Zero
    localparam int unsigned PSW_I = 2;         // Interrupt mask
    localparam int unsigned PSW_D = 3;         // Decimal mode
    localparam int unsigned PSW_B = 4;         // Break
    localparam int unsigned PSW_T = 5;         // Index X memory mode
    localparam int unsigned PSW_V = 6;         // Overflow
    localparam int unsigned PSW_N = 7;         // Negative

    // Reset value: mask set, all else cleared
    localparam logic [DATA_W-1:0] PSW_RESET = 8'h04;

    // ==================
    // Instruction register fields
    localparam int unsigned INSTR_OP_LSB  = 0; // Opcode field base
    localparam int unsigned INSTR_OP_W    = 4; // Opcode field width
    localparam int unsigned INSTR_BIT_LSB = 4; // Tested bit index base
    localparam int unsigned INSTR_BIT_W   = 3; // Tested bit index width
    localparam int unsigned INSTR_TAKEN   = 7; // Branch outcome, read

    // ==================
    // BCD digit limits
    localparam logic [4:0] BCD_DIGIT_MAX = 5'h09; // Largest digit
    localparam logic [4:0] BCD_ADJUST    = 5'h06; // Decimal correction

    // Divide-by-zero answer
    localparam logic [DATA_W-1:0] DIV_ZERO_QUOT = 8'hff;

    // ==================
    // Opcodes of the instruction register
    typedef enum logic [3:0] {
        OP_NOP    = 4'h0,   // No operation
        OP_ADC    = 4'h1,   // Add with carry
        OP_SBC    = 4'h2,   // Subtract with borrow
        OP_SEC    = 4'h3,   // Set carry
        OP_CLC    = 4'h4,   // Clear carry
        OP_SED    = 4'h5,   // Set decimal
        OP_CLD    = 4'h6,   // Clear decimal
        OP_SEI    = 4'h7,   // Set interrupt mask
        OP_CLI    = 4'h8,   // Clear interrupt mask
        OP_SET    = 4'h9,   // Set index memory mode
        OP_CLT    = 4'ha,   // Clear index memory mode
        OP_MUL    = 4'hb,   // Multiply
        OP_DIV    = 4'hc,   // Divide
        OP_BBS    = 4'hd,   // Branch if request bit high
        OP_BBC    = 4'he    // Branch if request bit low
    } opcode_t;

endpackage : cpu_flag_pkg

// ---- design/alu_if.sv ----
// Operand and result bundle between the core and its arithmetic units
`timescale 1ns/1ps
`default_nettype none
interface alu_if;
    logic [7:0] a;          // First operand / low dividend
    logic [7:0] b;          // Second operand / divisor
    logic [7:0] hi;         // High dividend byte
    logic       carry_in;   // Carry flag in
    logic       subtract;   // Subtract instead of add
    logic       decimal;    // Decimal arithmetic
    logic       is_div;     // Divide instead of multiply
    logic [7:0] sum;        // Add/subtract result
    logic       carry_out;  // Carry flag out
    logic       ovf;        // Binary overflow
    logic [7:0] md_lo;      // Product low / quotient
    logic [7:0] md_hi;      // Product high / remainder

    modport core   (output a, b, hi, carry_in, subtract, decimal, is_div,
                    input  sum, carry_out, ovf, md_lo, md_hi);
    modport addsub (input  a, b, carry_in, subtract, decimal,
                    output sum, carry_out, ovf);
    modport muldiv (input  a, b, hi, is_div,
                    output md_lo, md_hi);
endinterface : alu_if
`default_nettype wire

// ---- design/bcd_addsub.sv ----
// Binary and packed-BCD add with carry / subtract with borrow
`timescale 1ns/1ps
`default_nettype none
module bcd_addsub
    import cpu_flag_pkg::*;
(
    alu_if.addsub alu                  // Operands in, result out
);

    logic [7:0] bop;                   // Second operand, inverted on sub
    logic [8:0] bin;                   // Binary sum with carry
    logic [4:0] lo;                    // Low digit work value
    logic [4:0] hi;                    // High digit work value
    logic       lc;                    // Low digit carry/borrow
    logic       hc;                    // High digit carry/borrow

    // ==================
    // Combined adder
    always_comb begin
        bop = alu.subtract ? ~alu.b : alu.b;
        bin = {1'b0, alu.a} + {1'b0, bop} + {8'h00, alu.carry_in};
        lo  = 5'h00;
        hi  = 5'h00;
        lc  = 1'b0;
        hc  = 1'b0;
        // Overflow from the binary sum in both modes
        alu.ovf = (alu.a[7] == bop[7]) && (bin[7] != alu.a[7]);
        if (!alu.decimal) begin
            // Plain binary
            alu.sum       = bin[7:0];
            alu.carry_out = bin[8];
        end else if (!alu.subtract) begin
            // Decimal add, digit by digit
            lo = {1'b0, alu.a[3:0]} + {1'b0, alu.b[3:0]}
                 + {4'h0, alu.carry_in};
            lc = lo > BCD_DIGIT_MAX;
            if (lc) begin
                lo = lo + BCD_ADJUST;
            end
            hi = {1'b0, alu.a[7:4]} + {1'b0, alu.b[7:4]} + {4'h0, lc};
            hc = hi > BCD_DIGIT_MAX;
            if (hc) begin
                hi = hi + BCD_ADJUST;
            end
            alu.sum       = {hi[3:0], lo[3:0]};
            alu.carry_out = hc;
        end else begin
            // Decimal subtract, borrow when carry clear
            lo = {1'b0, alu.a[3:0]} - {1'b0, alu.b[3:0]}
                 - {4'h0, ~alu.carry_in};
            lc = lo[4];
            if (lc) begin
                lo = lo - BCD_ADJUST;
            end
            hi = {1'b0, alu.a[7:4]} - {1'b0, alu.b[7:4]} - {4'h0, lc};
            hc = hi[4];
            if (hc) begin
                hi = hi - BCD_ADJUST;
            end
            alu.sum       = {hi[3:0], lo[3:0]};
            alu.carry_out = ~hc;
        end
    end

endmodule : bcd_addsub
`default_nettype wire

// ---- design/mul_div_unit.sv ----
// Plain binary multiply and divide, flag-independent
`timescale 1ns/1ps
`default_nettype none
module mul_div_unit
    import cpu_flag_pkg::*;
(
    alu_if.muldiv alu                  // Operands in, result out
);

    logic [15:0] prod;                 // Full product
    logic [15:0] dvd;                  // Dividend Y:A
    logic [15:0] quot;                 // Full quotient
    logic [15:0] rem;                  // Remainder

    // ==================
    // Binary only: no decimal or index mode input exists here
    always_comb begin
        prod = {8'h00, alu.a} * {8'h00, alu.b};
        dvd  = {alu.hi, alu.a};
        if (alu.b == 8'h00) begin
            // Divide by zero: fixed quotient, dividend low kept
            quot = {8'h00, DIV_ZERO_QUOT};
            rem  = {8'h00, alu.a};
        end else begin
            quot = dvd / {8'h00, alu.b};
            rem  = dvd % {8'h00, alu.b};
        end
        alu.md_lo = alu.is_div ? quot[7:0] : prod[7:0];
        alu.md_hi = alu.is_div ? rem[7:0]  : prod[15:8];
    end

endmodule : mul_div_unit
`default_nettype wire

// ---- dv/cpu_flag_sva.sv ----
// Port checker for the status-flag core
`timescale 1ns/1ps
`default_nettype none
module cpu_flag_sva
    import cpu_flag_pkg::*;
(
    input wire logic              clk,          // Clock
    input wire logic              arst_n,       // Reset, low
    input wire logic              psel,         // Select
    input wire logic              penable,      // Access phase
    input wire logic              pwrite,       // Write
    input wire logic [APB_AW-1:0] paddr,        // Address
    input wire logic [APB_DW-1:0] pwdata,       // Write data
    input wire logic [3:0]        pstrb,        // Strobes
    input wire logic [APB_DW-1:0] prdata,       // Read data
    input wire logic              pready,       // Ready
    input wire logic              pslverr,      // Error
    input wire logic [DATA_W-1:0] irq_set,      // Requests
    input wire logic [DATA_W-1:0] processor_status_word, // Flags
    input wire logic              branch_taken, // Test outcome
    input wire logic              instr_done    // Exec pulse
);
    // ==================
    // Decode
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic       acc; // Access phase
    logic       iwr; // Instruction issue
    logic       bad; // Unmapped address
    logic [3:0] op;  // Issued opcode
    logic [7:0] psw; // Status word
    assign acc = psel && penable;
    assign iwr = acc && pwrite && pstrb[0] && paddr == ADDR_INSTR;
    assign bad = paddr > ADDR_IRQ_VIS || paddr[1:0] != 2'h0;
    assign op  = pwdata[3:0];
    assign psw = processor_status_word;
    // Issue steps
    sequence s_muldiv;
        iwr && (op == OP_MUL || op == OP_DIV);
    endsequence
    sequence s_pulse;
        instr_done ##1 !instr_done;
    endsequence
    // ==================
    // Properties
    a_reset_mask: assert property ($rose(arst_n) |-> psw == PSW_RESET)
        else $error("status word wrong after reset");
    a_muldiv_psw: assert property (s_muldiv |=> $stable(psw))
        else $error("multiply or divide changed flags");
    a_sed_dec: assert property (iwr && op == OP_SED |=> psw[PSW_D])
        else $error("decimal flag not set");
    a_sec_carry: assert property (iwr && op == OP_SEC |=> psw[PSW_C])
        else $error("carry not set");
    a_done_pulse: assert property (iwr |=> s_pulse)
        else $error("done pulse wrong");
    a_done_cause: assert property (instr_done |-> $past(iwr))
        else $error("done pulse without issue");
    a_bad_error: assert property (acc && bad |-> pslverr && prdata == '0)
        else $error("unmapped access not refused");
    a_good_quiet: assert property (acc && !bad |-> !pslverr)
        else $error("mapped access refused");
    a_idle_zero: assert property (!(acc && !pwrite) |-> prdata == '0)
        else $error("read data outside read");
    a_ready_high: assert property (pready && prdata[31:8] == 24'h0)
        else $error("ready low or upper data set");
endmodule : cpu_flag_sva
bind cpu_status_flag_logic cpu_flag_sva u_cpu_flag_sva (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_set(irq_set), .processor_status_word(processor_status_word),
    .branch_taken(branch_taken), .instr_done(instr_done));
`default_nettype wire

// ---- dv/prog_model.sv ----
// Program stream model: issues register and instruction traffic
`timescale 1ns/1ps
`default_nettype none
module prog_model
    import cpu_flag_pkg::*;
(
    input  wire logic              clk,     // Core clock
    input  wire logic [APB_DW-1:0] prdata,  // Read data
    input  wire logic              pready,  // Ready
    input  wire logic              pslverr, // Error
    output logic                   psel,    // Select
    output logic                   penable, // Access phase
    output logic                   pwrite,  // Direction
    output logic      [APB_AW-1:0] paddr,   // Address
    output logic      [APB_DW-1:0] pwdata,  // Write data
    output logic      [3:0]        pstrb,   // Strobes
    output logic                   hung     // Ready never came
);
    logic arith_q; // Last op was add/subtract
    logic irq_q;   // Request write not yet spaced
    // Idle bus at start
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'h0;
        hung = 1'b0;
        arith_q = 1'b0;
        irq_q = 1'b0;
    end
    // One transfer, held until ready at a rising edge
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [7:0] d, output logic [7:0] q, output logic e);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        pstrb <= {3'h0, w};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        hung <= (pready !== 1'b1);
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : xfer
    // Register write, tracking spacing state
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic       e;
        if (a == ADDR_INSTR) begin
            arith_q = d[3:0] == OP_ADC || d[3:0] == OP_SBC;
            irq_q = 1'b0;
        end
        if (a == ADDR_IRQ_REQ)
            irq_q = 1'b1;
        xfer(1'b1, a, d, q, e);
    endtask : wr
    // Issue an instruction, spacing where the program must
    task automatic exec(input opcode_t op, input logic [2:0] b);
        if ((arith_q && (op == OP_SEC || op == OP_CLC || op == OP_CLD))
            || (irq_q && (op == OP_BBS || op == OP_BBC)))
            wr(ADDR_INSTR, {4'h0, OP_NOP});
        wr(ADDR_INSTR, {1'b0, b, op});
    endtask : exec
endmodule : prog_model
`default_nettype wire

// ---- dv/cpu_status_flag_logic_bench.sv ----
// Self-checking bench for the status-flag core
`timescale 1ns/1ps
`default_nettype none
module cpu_status_flag_logic_bench
    import cpu_flag_pkg::*;
;
    logic        clk;     // Core clock
    logic        arst_n;  // Reset, low
    logic        psel, penable, pwrite, pready, pslverr; // Bus
    logic [7:0]  paddr;   // Address
    logic [31:0] pwdata, prdata; // Data
    logic [3:0]  pstrb;   // Strobes
    logic [7:0]  irq_set; // Requests
    logic [7:0]  psw;     // Flags
    logic        taken, done, hung; // Outcomes
    int          fails, checked; // Tallies
    prog_model u_prog_model (.clk(clk), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .hung(hung));
    cpu_status_flag_logic u_cpu_status_flag_logic (.clk(clk),
        .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq_set(irq_set),
        .processor_status_word(psw), .branch_taken(taken),
        .instr_done(done));
    // ==================
    // Clock, compare and verdict
    always #20 clk = ~clk;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tally_and_finish;
        if (fails == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    // Read a register and compare, no error expected
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        logic       e;
        u_prog_model.xfer(1'b0, a, 8'h00, q, e);
        chk(q, exp);
        chk({7'h0, e}, 8'h00);
    endtask : rdc
    // ==================
    // Scenarios
    task automatic t_reset_map;
        logic [7:0] q;
        logic       e;
        chk(psw, PSW_RESET);
        rdc(ADDR_PSW, PSW_RESET);
        u_prog_model.xfer(1'b0, 8'h20, 8'h00, q, e);
        chk({7'h0, e}, 8'h01);
        u_prog_model.wr(ADDR_IRQ_VIS, 8'hff);
        rdc(ADDR_IRQ_VIS, 8'h00);
    endtask : t_reset_map
    task automatic t_as(input logic d, sub, input logic [7:0] a, b,
        input logic cin, input logic [7:0] exp, input logic cout);
        u_prog_model.exec(d ? OP_SED : OP_CLD, 3'h0);
        u_prog_model.wr(ADDR_ACC, a);
        u_prog_model.wr(ADDR_OPND, b);
        u_prog_model.exec(cin ? OP_SEC : OP_CLC, 3'h0);
        u_prog_model.exec(sub ? OP_SBC : OP_ADC, 3'h0);
        rdc(ADDR_ACC, exp);
        chk({7'h0, psw[PSW_C]}, {7'h0, cout});
    endtask : t_as
    task automatic t_muldiv;
        logic [7:0] p;
        u_prog_model.exec(OP_SED, 3'h0);
        u_prog_model.exec(OP_SET, 3'h0);
        u_prog_model.wr(ADDR_XMEM, 8'h55);
        u_prog_model.wr(ADDR_ACC, 8'h12);
        // Operands whose BCD and binary answers differ
        u_prog_model.wr(ADDR_OPND, 8'h09);
        p = psw;
        u_prog_model.exec(OP_MUL, 3'h0);
        rdc(ADDR_ACC, 8'ha2);
        rdc(ADDR_YREG, 8'h00);
        u_prog_model.exec(OP_DIV, 3'h0);
        rdc(ADDR_ACC, 8'h12);
        rdc(ADDR_YREG, 8'h00);
        u_prog_model.wr(ADDR_OPND, 8'h00);
        u_prog_model.exec(OP_DIV, 3'h0);
        rdc(ADDR_ACC, 8'hff);
        rdc(ADDR_YREG, 8'h12);
        rdc(ADDR_XMEM, 8'h55);
        chk(psw, p);
        arst_n <= 1'b0;
        @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        chk(psw, PSW_RESET);
    endtask : t_muldiv
    task automatic t_irq_lag;
        u_prog_model.wr(ADDR_IRQ_REQ, 8'h08);
        u_prog_model.wr(ADDR_INSTR, {1'b0, 3'h3, OP_BBS});
        chk({7'h0, taken}, 8'h00);
        u_prog_model.exec(OP_BBS, 3'h3);
        chk({7'h0, taken}, 8'h01);
        irq_set <= 8'h20;
        @(posedge clk);
        irq_set <= 8'h00;
        u_prog_model.exec(OP_BBC, 3'h5);
        chk({7'h0, taken}, 8'h01);
        u_prog_model.exec(OP_BBC, 3'h5);
        chk({7'h0, taken}, 8'h00);
        rdc(ADDR_IRQ_VIS, 8'h28);
    endtask : t_irq_lag
    // ==================
    // Main sequence and hang guards
    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        irq_set = 8'h00;
        fails = 0;
        checked = 0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        t_reset_map();
        t_as(1'b0, 1'b0, 8'h19, 8'h28, 1'b0, 8'h41, 1'b0);
        t_as(1'b1, 1'b0, 8'h19, 8'h28, 1'b0, 8'h47, 1'b0);
        t_as(1'b1, 1'b0, 8'h99, 8'h01, 1'b0, 8'h00, 1'b1);
        t_as(1'b1, 1'b1, 8'h10, 8'h01, 1'b1, 8'h09, 1'b1);
        t_as(1'b1, 1'b1, 8'h00, 8'h01, 1'b1, 8'h99, 1'b0);
        t_as(1'b0, 1'b1, 8'h00, 8'h01, 1'b1, 8'hff, 1'b0);
        t_muldiv();
        t_irq_lag();
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        tally_and_finish();
    end
    always @(posedge clk) begin
        if (hung === 1'b1) begin
            fails++;
            tally_and_finish();
        end
    end
endmodule : cpu_status_flag_logic_bench
`default_nettype wire
